// file: pin_change_cfg.svh
/*
 Register offsets, field positions, reset values and widths of the pin-change block.
 Assumes a 32-bit Wishbone word per register, byte addresses.
*/
`ifndef PIN_CHANGE_CFG_SVH
`define PIN_CHANGE_CFG_SVH
`define PC_NUM_PINS 6
`define PC_ADR_RISE 4'h0
`define PC_ADR_FALL 4'h4
`define PC_ADR_FLAGS 4'h8
`define PC_ADR_CTRL 4'hc
`define PC_CTRL_MASTER_BIT 0
`define PC_CTRL_SUMMARY_BIT 1
`define PC_CTRL_SLEEP_BIT 2
`define PC_ENABLE_RESET 6'h00
`define PC_FLAGS_RESET 6'h00
`endif

// file: pin_change_irq.sv
/*
 Pin-change interrupt controller with a classic Wishbone register slave.
 Assumes pins are asynchronous, bus master on clk_i, synchronous reset.
*/
`timescale 1ns/100ps
`default_nettype none
`include "pin_change_cfg.svh"
module pin_change_irq #(
  parameter int NUM_PINS = `PC_NUM_PINS
) (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire pin_change_pkg::wb_req_t wb_req_i,
  output pin_change_pkg::wb_rsp_t wb_rsp_o,
  input wire logic [NUM_PINS-1:0] port_pin_i,
  input wire logic sleep_i,
  output logic irq_o,
  output logic wake_o
);
  import pin_change_pkg::*;

  initial begin
    if (NUM_PINS < 1 || NUM_PINS > 8) $error("pin_change_irq: NUM_PINS must be 1..8");
  end

  ////////////////////////////////////////////////////////////////////////////
  logic [NUM_PINS-1:0] rise_det;
  logic [NUM_PINS-1:0] fall_det;

  pin_edge_detect #(
    .WIDTH(NUM_PINS)
  ) u_edge (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .pin_i(port_pin_i),
    .rise_o(rise_det),
    .fall_o(fall_det)
  );

  ////////////////////////////////////////////////////////////////////////////
  logic [NUM_PINS-1:0] rise_en_ff;
  logic [NUM_PINS-1:0] fall_en_ff;
  logic [NUM_PINS-1:0] flags_ff;
  logic master_en_ff;
  logic irq_ff;
  logic wake_ff;
  bus_state_t bus_ff;
  logic [31:0] rdata_ff;
  logic [NUM_PINS-1:0] nxt_rise_en;
  logic [NUM_PINS-1:0] nxt_fall_en;
  logic [NUM_PINS-1:0] nxt_flags;
  logic nxt_master_en;
  logic nxt_irq;
  logic nxt_wake;
  bus_state_t nxt_bus;
  logic [31:0] nxt_rdata;
  logic [NUM_PINS-1:0] hit;
  logic summary;
  logic wr_take;
  logic rd_take;

  // Edge hit per pin; detection ignores master enable
  genvar g;
  for (g = 0; g < NUM_PINS; g++) begin : g_hit
    assign hit[g] = (rise_en_ff[g] & rise_det[g]) | (fall_en_ff[g] & fall_det[g]);
  end

  assign summary = |flags_ff;

  // Request taken in idle; ack follows one cycle later
  assign wr_take = (bus_ff == BUS_IDLE) & wb_req_i.cyc & wb_req_i.stb & wb_req_i.we;
  assign rd_take = (bus_ff == BUS_IDLE) & wb_req_i.cyc & wb_req_i.stb & ~wb_req_i.we;

  ////////////////////////////////////////////////////////////////////////////
  always_comb begin
    nxt_rise_en = rise_en_ff;
    nxt_fall_en = fall_en_ff;
    nxt_flags = flags_ff;
    nxt_master_en = master_en_ff;
    nxt_bus = bus_ff;
    nxt_rdata = rdata_ff;
    case (bus_ff)
      BUS_IDLE: begin
        if (wb_req_i.cyc && wb_req_i.stb) begin
          nxt_bus = BUS_ACK;
        end
      end
      BUS_ACK: begin
        nxt_bus = BUS_IDLE;
      end
      default: begin
        nxt_bus = BUS_IDLE;
      end
    endcase
    if (wr_take && wb_req_i.sel[0]) begin
      case (wb_req_i.adr)
        `PC_ADR_RISE: nxt_rise_en = wb_req_i.dat[NUM_PINS-1:0];
        `PC_ADR_FALL: nxt_fall_en = wb_req_i.dat[NUM_PINS-1:0];
        `PC_ADR_FLAGS: nxt_flags = flags_ff & wb_req_i.dat[NUM_PINS-1:0];
        `PC_ADR_CTRL: nxt_master_en = wb_req_i.dat[`PC_CTRL_MASTER_BIT];
        default: nxt_master_en = master_en_ff;
      endcase
    end
    // Set wins over a clearing write in the same cycle; sleep does not gate it
    nxt_flags = nxt_flags | hit;
    nxt_rdata = 32'h0000_0000;
    if (rd_take) begin
      case (wb_req_i.adr)
        `PC_ADR_RISE: nxt_rdata[NUM_PINS-1:0] = rise_en_ff;
        `PC_ADR_FALL: nxt_rdata[NUM_PINS-1:0] = fall_en_ff;
        `PC_ADR_FLAGS: nxt_rdata[NUM_PINS-1:0] = flags_ff;
        `PC_ADR_CTRL: begin
          nxt_rdata[`PC_CTRL_MASTER_BIT] = master_en_ff;
          nxt_rdata[`PC_CTRL_SUMMARY_BIT] = summary;
          nxt_rdata[`PC_CTRL_SLEEP_BIT] = sleep_i;
        end
        default: nxt_rdata = 32'h0000_0000;
      endcase
    end
    nxt_irq = master_en_ff & summary;
    nxt_wake = master_en_ff & summary & sleep_i;
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      rise_en_ff <= NUM_PINS'(`PC_ENABLE_RESET);
      fall_en_ff <= NUM_PINS'(`PC_ENABLE_RESET);
      flags_ff <= NUM_PINS'(`PC_FLAGS_RESET);
      master_en_ff <= 1'b0;
      irq_ff <= 1'b0;
      wake_ff <= 1'b0;
      bus_ff <= BUS_IDLE;
      rdata_ff <= 32'h0000_0000;
    end else begin
      rise_en_ff <= nxt_rise_en;
      fall_en_ff <= nxt_fall_en;
      flags_ff <= nxt_flags;
      master_en_ff <= nxt_master_en;
      irq_ff <= nxt_irq;
      wake_ff <= nxt_wake;
      bus_ff <= nxt_bus;
      rdata_ff <= nxt_rdata;
    end
  end

  // Unmapped reads return zero, writes are dropped, ack always given
  assign wb_rsp_o.ack = (bus_ff == BUS_ACK);
  assign wb_rsp_o.dat = rdata_ff;
  assign irq_o = irq_ff;
  assign wake_o = wake_ff;
endmodule : pin_change_irq
`default_nettype wire

// file: pin_change_pkg.sv
/*
 Types shared by the pin-change block.
 Assumes the configuration header is on the include path.
*/
`include "pin_change_cfg.svh"
package pin_change_pkg;
  typedef logic [`PC_NUM_PINS-1:0] pin_vec_t;
  typedef struct packed {
    logic cyc;
    logic stb;
    logic we;
    logic [3:0] adr;
    logic [3:0] sel;
    logic [31:0] dat;
  } wb_req_t;
  typedef struct packed {
    logic ack;
    logic [31:0] dat;
  } wb_rsp_t;
  typedef enum logic [1:0] {
    BUS_IDLE,
    BUS_ACK
  } bus_state_t;
endpackage : pin_change_pkg

// file: pin_change_sva.sv
/* Port checker of the pin-change block.
 Bound from tb; sees the top ports only. */
`timescale 1ns/100ps
`default_nettype none
module pin_change_sva (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire pin_change_pkg::wb_req_t wb_req_i,
  input wire pin_change_pkg::wb_rsp_t wb_rsp_o,
  input wire logic sleep_i,
  input wire logic irq_o,
  input wire logic wake_o
);
  logic wr_ctrl;
  logic m_ff;
  default clocking @(posedge clk_i); endclocking
  default disable iff (rst_i);
  sequence taken;
    wb_req_i.cyc && wb_req_i.stb && !wb_rsp_o.ack;
  endsequence
  // Shadow master enable, so irq and wake are tied to a cause
  assign wr_ctrl = wb_req_i.cyc && wb_req_i.stb && !wb_rsp_o.ack && wb_req_i.we
    && wb_req_i.sel[0] && wb_req_i.adr == 4'hc;
  always_ff @(posedge clk_i)
    m_ff <= rst_i ? 1'b0 : (wr_ctrl ? wb_req_i.dat[0] : m_ff);
  a_ack_answer: assert property (taken |=> wb_rsp_o.ack) else $error("no ack");
  a_ack_pulse: assert property (wb_rsp_o.ack |=> !wb_rsp_o.ack) else $error("ack held");
  a_dat_idle: assert property (!wb_rsp_o.ack |-> wb_rsp_o.dat == 32'h0)
    else $error("idle data");
  a_upper_zero: assert property (wb_rsp_o.ack |-> wb_rsp_o.dat[31:6] == 26'h0)
    else $error("upper bits set");
  a_irq_master: assert property (!m_ff |=> !irq_o)
    else $error("irq without master");
  a_wake_master: assert property (wake_o |-> $past(m_ff))
    else $error("wake without master");
  a_wake_sleep: assert property (wake_o |-> $past(sleep_i))
    else $error("wake while awake");
  a_wake_irq: assert property (wake_o |-> irq_o)
    else $error("wake without irq");
endmodule : pin_change_sva
`default_nettype wire

// file: pin_edge_detect.sv
/*
 Per-pin synchroniser and edge detector.
 Assumes pins are asynchronous to clk_i.
*/
`timescale 1ns/100ps
`default_nettype none
module pin_edge_detect #(
  parameter int WIDTH = 6
) (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic [WIDTH-1:0] pin_i,
  output logic [WIDTH-1:0] rise_o,
  output logic [WIDTH-1:0] fall_o
);
  logic [WIDTH-1:0] meta_ff;
  logic [WIDTH-1:0] sync_ff;
  logic [WIDTH-1:0] prev_ff;
  logic [WIDTH-1:0] nxt_meta;
  logic [WIDTH-1:0] nxt_sync;
  logic [WIDTH-1:0] nxt_prev;

  initial begin
    if (WIDTH < 1) $error("pin_edge_detect: WIDTH must be at least 1");
  end

  always_comb begin
    nxt_meta = pin_i;
    nxt_sync = meta_ff;
    nxt_prev = sync_ff;
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      meta_ff <= '0;
      sync_ff <= '0;
      prev_ff <= '0;
    end else begin
      meta_ff <= nxt_meta;
      sync_ff <= nxt_sync;
      prev_ff <= nxt_prev;
    end
  end

  // Compare current and previous synchronised sample
  genvar g;
  for (g = 0; g < WIDTH; g++) begin : g_edge
    assign rise_o[g] = sync_ff[g] & ~prev_ff[g];
    assign fall_o[g] = ~sync_ff[g] & prev_ff[g];
  end
endmodule : pin_edge_detect
`default_nettype wire

// file: pin_source.sv
/* External pin source of the port.
 Levels change just after a clock edge. */
`timescale 1ns/100ps
`default_nettype none
module pin_source (
  input wire logic clk_i,
  output logic [5:0] pin_o
);
  initial pin_o = 6'h00;
  task automatic drive(input logic [5:0] v);
    @(posedge clk_i);
    pin_o <= v;
  endtask : drive
endmodule : pin_source
`default_nettype wire

// file: tb.sv
/* Bench of the pin-change block.
 Wishbone master task; pins from pin_source. */
`timescale 1ns/100ps
`default_nettype none
module tb;
  import pin_change_pkg::*;
  logic clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic sleep_i = 1'b0;
  logic irq_o;
  logic wake_o;
  wb_req_t req = '0;
  wb_rsp_t rsp;
  pin_vec_t pins;
  int miscompares = 0;
  int tests_run = 0;
  int cycles = 0;
  always #5 clk_i = ~clk_i;
  pin_source src_u (.clk_i(clk_i), .pin_o(pins));
  pin_change_irq dut_u (.clk_i(clk_i), .rst_i(rst_i), .wb_req_i(req), .wb_rsp_o(rsp),
    .port_pin_i(pins), .sleep_i(sleep_i), .irq_o(irq_o), .wake_o(wake_o));
  ////////////////////////////////////////
  task automatic print_verdict();
    $display("checks %0d mismatches %0d", tests_run, miscompares);
    if (miscompares == 0 && tests_run > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask : print_verdict
  always @(posedge clk_i) begin
    cycles++;
    if (cycles == 2000) begin
      miscompares++;
      print_verdict();
    end
  end
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp) begin
      miscompares++;
      $display("mismatch at %0t got %h exp %h", $time, got, exp);
    end
  endtask : chk
  // Reads compare against d; held until ack, no latency assumed
  task automatic acc(input logic we, input logic [3:0] a, input logic [7:0] d);
    @(posedge clk_i);
    req <= '{1'b1, 1'b1, we, a, 4'hf, {24'h0, d}};
    @(posedge clk_i);
    while (rsp.ack !== 1'b1) @(posedge clk_i);
    if (!we) chk(rsp.dat, {24'h0, d});
    req <= '0;
  endtask : acc
  task automatic idle(input int n);
    repeat (n) @(posedge clk_i);
  endtask : idle
  initial begin
    idle(4);
    rst_i <= 1'b0;
    acc(1'b0, 4'h0, 8'h00);
    acc(1'b0, 4'h4, 8'h00);
    acc(1'b0, 4'h8, 8'h00);
    acc(1'b1, 4'h0, 8'hff);
    acc(1'b0, 4'h0, 8'h3f);
    acc(1'b1, 4'h0, 8'h05);
    acc(1'b1, 4'h4, 8'h06);
    $display("regs done");
    src_u.drive(6'h3f);
    idle(6);
    acc(1'b0, 4'h8, 8'h05);
    chk({31'h0, irq_o}, 32'h0);
    src_u.drive(6'h00);
    idle(6);
    acc(1'b0, 4'h8, 8'h07);
    acc(1'b1, 4'hc, 8'h01);
    idle(2);
    chk({31'h0, irq_o}, 32'h1);
    acc(1'b0, 4'hc, 8'h03);
    sleep_i <= 1'b1;
    idle(2);
    chk({31'h0, wake_o}, 32'h1);
    acc(1'b0, 4'hc, 8'h07);
    $display("edges done");
    acc(1'b1, 4'h8, 8'hf8);
    acc(1'b0, 4'h8, 8'h00);
    acc(1'b1, 4'hc, 8'h00);
    src_u.drive(6'h01);
    idle(6);
    chk({31'h0, wake_o}, 32'h0);
    acc(1'b0, 4'h8, 8'h01);
    $display("sleep done");
    print_verdict();
  end
endmodule : tb
bind pin_change_irq pin_change_sva chk_u (.clk_i(clk_i), .rst_i(rst_i), .wb_req_i(wb_req_i),
  .wb_rsp_o(wb_rsp_o), .sleep_i(sleep_i), .irq_o(irq_o), .wake_o(wake_o));
`default_nettype wire
